// file: hw/cca_pkg.sv
package cca_pkg;
	localparam int NUM_CH    = 8;
	localparam int LOC_REGS  = 32;
	localparam int GLB_REGS  = 27;
	localparam int COE_WORDS = 40;
	localparam int FSK_GENS  = 4;
	localparam int FSK_WORDS = 32;
	localparam int SYNC_W    = 6;

	localparam logic [4:0] GLB_LAST_ADDR = 5'h19;
	localparam logic [4:0] GLB_R27_ADDR  = 5'h1c;
	localparam logic [4:0] GLB_R27_IDX   = 5'h1a;
	localparam logic [4:0] CHAN_EN_IDX   = 5'h05;
	localparam logic [4:0] FSK_SEL_IDX   = 5'h18;
	localparam logic [7:0] GLB_RESET     = 8'h00;
	localparam logic [2:0] PS_TOP        = 3'h4;
	localparam logic [3:0] PS_LOW        = 4'h1;
	localparam int         PS_AB_BIT     = 4;
	localparam int         MEM_FSK_BIT   = 4;
	localparam int         MEM_ZERO_BIT  = 3;
	localparam logic [3:0] COE_BLKS      = 4'h5;
	localparam logic [2:0] FSK_BLKS      = 3'h4;
	localparam logic [4:0] MEM_BYTES     = 5'h10;
	localparam logic [2:0] TOP_WORD      = 3'h7;
	localparam logic [5:0] SYNC_RST      = 6'h3f;
	localparam logic [2:0] LAST_BIT      = 3'h7;

	typedef enum logic [1:0] {
		K_LOCAL   = 2'b00,
		K_GLOBAL  = 2'b01,
		K_ILLEGAL = 2'b10,
		K_MEM     = 2'b11
	} cca_kind_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD  = 3'b001,
		S_WR   = 3'b010,
		S_RD   = 3'b011,
		S_SKIP = 3'b100
	} cca_state_t;

	typedef struct packed {
		logic      wr;
		cca_kind_t kind;
		logic [4:0] addr;
	} cca_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} cca_byte_t;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic       sdi;
		logic       gci_mode;
		logic [1:0] slot;
	} cca_pins_t;
endpackage

// file: hw/cca_shift.sv
`timescale 1ns/100ps
module cca_shift (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire cca_pkg::cca_pins_t pins,
	input  wire logic [7:0]        tx_byte,
	output cca_pkg::cca_pins_t     pins_s,
	output cca_pkg::cca_byte_t     rx,
	output logic                   cs_start,
	output logic                   cs_end,
	output logic                   sdo
);
	logic             sclk_d, cs_d;
	logic [2:0]       bitc;
	logic [7:0]       rxsh, txsh;
	logic [1:0]       load_p;
	logic             next_sclk_d, next_cs_d, next_cs_start, next_cs_end, next_sdo;
	logic [2:0]       next_bitc;
	logic [7:0]       next_rxsh, next_txsh;
	logic [1:0]       next_load_p;
	cca_pkg::cca_byte_t next_rx;
	logic             rise, fall;
	wire [cca_pkg::SYNC_W-1:0] sync_q;

	// two flops per pin; the first is seen only by the second
	genvar g;
	generate
		for (g = 0; g < cca_pkg::SYNC_W; g++) begin : g_sync
			logic s1, s2;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1 <= cca_pkg::SYNC_RST[g];
					s2 <= cca_pkg::SYNC_RST[g];
				end else if (clk_en) begin
					s1 <= pins[g];
					s2 <= s1;
				end
			end
			assign sync_q[g] = s2;
		end
	endgenerate
	assign pins_s = sync_q;  // one driver for the whole struct

	// sample on rising sclk, launch on falling; reply loads two cycles after
	// a byte so the core has had time to update it
	always_comb begin
		rise          = pins_s.sclk & ~sclk_d;
		fall          = ~pins_s.sclk & sclk_d;
		next_sclk_d   = pins_s.sclk;
		next_cs_d     = pins_s.cs_n;
		next_cs_start = cs_d & ~pins_s.cs_n;
		next_cs_end   = ~cs_d & pins_s.cs_n;
		next_bitc     = bitc;
		next_rxsh     = rxsh;
		next_txsh     = txsh;
		next_sdo      = sdo;
		next_rx       = '{valid: 1'b0, data: rx.data};
		next_load_p   = {load_p[0], 1'b0};
		if (next_cs_start) begin
			next_bitc = 3'h0;
			next_sdo  = 1'b0;
			next_txsh = 8'h00;
		end else if (!pins_s.cs_n && rise) begin
			next_rxsh = {rxsh[6:0], pins_s.sdi};
			next_bitc = bitc + 3'h1;
			if (bitc == cca_pkg::LAST_BIT) begin
				next_rx     = '{valid: 1'b1, data: {rxsh[6:0], pins_s.sdi}};
				next_load_p = {load_p[0], 1'b1};
			end
		end
		if (load_p[1]) begin
			next_txsh = tx_byte;
			next_sdo  = tx_byte[7];
		end else if (!pins_s.cs_n && fall && bitc != 3'h0) begin
			next_txsh = {txsh[6:0], 1'b0};
			next_sdo  = txsh[6];  // boundary fall is skipped: msb already out
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d   <= 1'b1;  // matches the synchroniser reset, so no false edge
			cs_d     <= 1'b1;
			cs_start <= 1'b0;
			cs_end   <= 1'b0;
			bitc     <= 3'h0;
			rxsh     <= 8'h00;
			txsh     <= 8'h00;
			sdo      <= 1'b0;
			rx       <= '0;
			load_p   <= 2'h0;
		end else if (clk_en) begin
			sclk_d   <= next_sclk_d;
			cs_d     <= next_cs_d;
			cs_start <= next_cs_start;
			cs_end   <= next_cs_end;
			bitc     <= next_bitc;
			rxsh     <= next_rxsh;
			txsh     <= next_txsh;
			sdo      <= next_sdo;
			rx       <= next_rx;
			load_p   <= next_load_p;
		end
	end
endmodule

// file: hw/cca_core.sv
`timescale 1ns/100ps
// Summary of operation
// - serial mode: first byte after chip select low is the command
// - chip select rise aborts register stepping, completed registers kept
// - monitor channel stepping never aborts; writes carry one byte per register
// - global addresses 0-25 and 28 valid, 26 and 27 reserved
// - global registers step like local registers
// - monitor channel takes global commands in any served slot
// - forty coefficient words per channel in five 8-word blocks
// - coefficient words keep 14 bits, low two bits dropped
// - monitor channel target is slot pins plus start byte bit four
// - memory commands move eight words, highest word first
// - chip select rise aborts memory block, completed words kept
// - each fsk memory holds four blocks of eight 16-bit words
// - fsk command: bits 2-0 block, bit 3 zero, bit 4 one
// - serial reads return identification byte first; writes shift out the byte left in mon_tx
// - monitor channel: start byte, command, data; reply starts with start byte
// - register commands move one to four bytes per low address bits
// - command byte: bit 7 write, bits 6-5 type, bits 4-0 address
// - multi-byte register access steps downward from addressed register
// - serial mode: per-channel enable bits broadcast local and coefficient writes
// - monitor bytes valid only after two consecutive identical frames
module cca_core #(
	parameter logic [7:0] ID_CODE = 8'h5a  // arbitrary identification value
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               cs_n,
	input  wire logic               sclk,
	input  wire logic               serial_cmd_in,
	input  wire logic               gci_mode,
	input  wire logic [1:0]         slot_select_pin,
	input  wire logic               mon_frame,
	input  wire cca_pkg::cca_byte_t mon_rx,
	output logic                    serial_reply_out,
	output cca_pkg::cca_byte_t      mon_tx,
	output logic                    cmd_busy
);
	cca_pkg::cca_pins_t  pins_s, pins_raw;
	cca_pkg::cca_byte_t  srx;
	logic                cs_start, cs_end;
	cca_pkg::cca_state_t state, next_state;
	cca_pkg::cca_cmd_t   cmd, next_cmd;
	cca_pkg::cca_byte_t  mon_last, next_mon_last, next_mon_tx;
	logic [4:0]          cnt, next_cnt;
	logic [7:0]          hi_byte, next_hi_byte;
	logic [2:0]          chan, next_chan;
	logic                fcnt, next_fcnt, taken, next_taken, next_busy;
	logic [7:0]          greg [cca_pkg::GLB_REGS];
	logic [15:0]         frd [cca_pkg::FSK_GENS];
	logic [7:0]          lrd [cca_pkg::NUM_CH];
	logic [13:0]         crd [cca_pkg::NUM_CH];
	logic                gci, in_v, mon_acc, wr_go, lo, blk_ok, g_ok, adv;
	logic [7:0]          in_b, tmask, rd_val, ps_reply;
	logic [4:0]          cur_reg, gidx, nbytes, fsk_a;
	logic [2:0]          cur_word, rd_ch;
	logic [1:0]          rd_fsk;
	logic [5:0]          coe_a;
	logic [15:0]         memw, mrd;
	cca_pkg::cca_cmd_t   in_cmd;

	assign pins_raw = {cs_n, sclk, serial_cmd_in, gci_mode, slot_select_pin}; // raw, synced in shifter
	cca_shift u_shift (
		.clk      (clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.pins     (pins_raw),
		.tx_byte  (mon_tx.data),
		.pins_s   (pins_s),
		.rx       (srx),
		.cs_start (cs_start),
		.cs_end   (cs_end),
		.sdo      (serial_reply_out)
	);

	function automatic logic [2:0] first_set(input logic [7:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (m[i]) begin
				r = i[2:0];
			end
		end
		return r;
	endfunction

	// address decode for the access in progress
	always_comb begin
		gci      = pins_s.gci_mode;
		mon_acc  = gci && mon_frame && mon_rx.valid && mon_last == mon_rx && !taken;
		in_v     = gci ? mon_acc : srx.valid;
		in_b     = gci ? mon_rx.data : srx.data;
		in_cmd   = cca_pkg::cca_cmd_t'(in_b);
		cur_reg  = cmd.addr - cnt;
		g_ok     = cur_reg <= cca_pkg::GLB_LAST_ADDR || cur_reg == cca_pkg::GLB_R27_ADDR;
		gidx     = (cur_reg == cca_pkg::GLB_R27_ADDR) ? cca_pkg::GLB_R27_IDX : cur_reg;
		cur_word = cca_pkg::TOP_WORD - cnt[3:1];
		lo       = cnt[0];
		coe_a    = {cmd.addr[2:0], cur_word};
		fsk_a    = {cmd.addr[1:0], cur_word};
		blk_ok   = in_cmd.addr[cca_pkg::MEM_FSK_BIT]
			? (!in_cmd.addr[cca_pkg::MEM_ZERO_BIT] && in_cmd.addr[2:0] < cca_pkg::FSK_BLKS)
			: (in_cmd.addr[3:0] < cca_pkg::COE_BLKS);
		nbytes   = (cmd.kind == cca_pkg::K_MEM) ? cca_pkg::MEM_BYTES
			: {3'h0, cmd.addr[1:0]} + 5'h01;
		tmask    = gci ? (8'h01 << chan) : greg[cca_pkg::CHAN_EN_IDX];
		rd_ch    = gci ? chan : first_set(greg[cca_pkg::CHAN_EN_IDX]);
		rd_fsk   = 2'(first_set({4'h0, greg[cca_pkg::FSK_SEL_IDX][3:0]}));
		memw     = {hi_byte, in_b};
		wr_go    = state == cca_pkg::S_WR && in_v;
		ps_reply = {cca_pkg::PS_TOP, chan[0], cca_pkg::PS_LOW};
	end

	// read data for the current step; coefficient low bits read as zero
	always_comb begin
		mrd = cmd.addr[cca_pkg::MEM_FSK_BIT] ? frd[rd_fsk]
			: {crd[rd_ch], 2'b00};
		case (cmd.kind)
			cca_pkg::K_LOCAL:  rd_val = lrd[rd_ch];
			cca_pkg::K_GLOBAL: rd_val = g_ok ? greg[gidx] : 8'h00;
			cca_pkg::K_MEM:    rd_val = lo ? mrd[7:0] : mrd[15:8];
			default:           rd_val = 8'h00;
		endcase
	end

	// per-channel local registers and coefficient memory; broadcast writes
	// land in every enabled channel in the same cycle
	genvar c;
	generate
		for (c = 0; c < cca_pkg::NUM_CH; c++) begin : g_ch
			logic [7:0]  lreg [cca_pkg::LOC_REGS];
			logic [13:0] coe [cca_pkg::COE_WORDS];
			always_ff @(posedge clk) begin
				if (clk_en && tmask[c] && wr_go && cmd.kind == cca_pkg::K_LOCAL) begin
					lreg[cur_reg] <= in_b;
				end
				if (clk_en && tmask[c] && wr_go && cmd.kind == cca_pkg::K_MEM
					&& !cmd.addr[cca_pkg::MEM_FSK_BIT] && lo) begin
					coe[coe_a] <= memw[15:2];
				end
			end
			assign lrd[c] = lreg[cur_reg];
			assign crd[c] = coe[coe_a];
		end
	endgenerate

	// fsk memories are shared; every selected generator takes the word
	genvar f;
	generate
		for (f = 0; f < cca_pkg::FSK_GENS; f++) begin : g_fsk
			logic [15:0] fmem [cca_pkg::FSK_WORDS];
			always_ff @(posedge clk) begin
				if (clk_en && greg[cca_pkg::FSK_SEL_IDX][f] && wr_go && lo
					&& cmd.kind == cca_pkg::K_MEM && cmd.addr[cca_pkg::MEM_FSK_BIT]) begin
					fmem[fsk_a] <= memw;
				end
			end
			assign frd[f] = fmem[fsk_a];
		end
	endgenerate

	// global registers reset so channel and generator enables start cleared
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cca_pkg::GLB_REGS; i++) begin
				greg[i] <= cca_pkg::GLB_RESET;
			end
		end else if (clk_en && wr_go && cmd.kind == cca_pkg::K_GLOBAL && g_ok) begin
			greg[gidx] <= in_b;
		end
	end

	// command sequencer
	always_comb begin
		next_state    = state;
		next_cmd      = cmd;
		next_cnt      = cnt;
		next_hi_byte  = hi_byte;
		next_chan     = chan;
		next_fcnt     = fcnt;
		next_mon_tx   = mon_tx;
		next_mon_last = mon_frame ? mon_rx : mon_last;
		next_taken    = mon_acc ? 1'b1 : ((mon_frame && mon_rx != mon_last) ? 1'b0 : taken);
		adv           = gci ? (mon_frame && fcnt) : in_v;
		case (state)
			cca_pkg::S_IDLE: begin
				if (!gci && cs_start) begin
					next_state = cca_pkg::S_CMD;
				end else if (gci && in_v && in_b[7:5] == cca_pkg::PS_TOP
					&& in_b[3:0] == cca_pkg::PS_LOW) begin
					next_chan  = {pins_s.slot, in_b[cca_pkg::PS_AB_BIT]};
					next_state = cca_pkg::S_CMD;
				end
			end
			cca_pkg::S_CMD: begin
				if (in_v) begin
					next_cmd = in_cmd;
					next_cnt = 5'h00;
					if (in_cmd.kind == cca_pkg::K_ILLEGAL
						|| (in_cmd.kind == cca_pkg::K_MEM && !blk_ok)) begin
						next_state = gci ? cca_pkg::S_IDLE : cca_pkg::S_SKIP;
					end else if (in_cmd.wr) begin
						next_state = cca_pkg::S_WR;
					end else begin
						next_state  = cca_pkg::S_RD;
						next_fcnt   = 1'b0;
						next_mon_tx = gci ? cca_pkg::cca_byte_t'{valid: 1'b1, data: ps_reply}
							: cca_pkg::cca_byte_t'{valid: 1'b0, data: ID_CODE};
					end
				end
			end
			cca_pkg::S_WR: begin
				if (in_v) begin
					next_hi_byte = lo ? hi_byte : in_b;
					next_cnt     = cnt + 5'h01;
					if (next_cnt == nbytes) begin
						next_state = gci ? cca_pkg::S_IDLE : cca_pkg::S_SKIP;
					end
				end
			end
			cca_pkg::S_RD: begin
				if (gci && mon_frame) begin
					next_fcnt = ~fcnt;  // each upstream byte stands two frames
				end
				if (adv) begin
					if (cnt == nbytes) begin
						next_mon_tx.valid = 1'b0;
						next_state = gci ? cca_pkg::S_IDLE : cca_pkg::S_SKIP;
					end else begin
						next_mon_tx.data = rd_val;
						next_cnt         = cnt + 5'h01;
					end
				end
			end
			cca_pkg::S_SKIP: begin
				next_state = cca_pkg::S_SKIP;  // extra bytes ignored until deselect
			end
			default: begin
				next_state = cca_pkg::S_IDLE;
			end
		endcase
		// deselect ends any serial command; finished steps are already stored
		if (!gci && cs_end) begin
			next_state = cca_pkg::S_IDLE;
		end
		next_busy = next_state != cca_pkg::S_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= cca_pkg::S_IDLE;
			cmd      <= '0;
			cnt      <= 5'h00;
			hi_byte  <= 8'h00;
			chan     <= 3'h0;
			fcnt     <= 1'b0;
			taken    <= 1'b0;
			mon_last <= '0;
			mon_tx   <= '0;
			cmd_busy <= 1'b0;
		end else if (clk_en) begin
			state    <= next_state;
			cmd      <= next_cmd;
			cnt      <= next_cnt;
			hi_byte  <= next_hi_byte;
			chan     <= next_chan;
			fcnt     <= next_fcnt;
			taken    <= next_taken;
			mon_last <= next_mon_last;
			mon_tx   <= next_mon_tx;
			cmd_busy <= next_busy;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_cmd_first;
		clk_en && state == cca_pkg::S_IDLE && !gci && cs_start |=> state == cca_pkg::S_CMD;
	endproperty
	a_cmd_first: assert property (p_cmd_first) else $error("no command phase");

	property p_abort;
		clk_en && !gci && cs_end |=> state == cca_pkg::S_IDLE && !cmd_busy;
	endproperty
	a_abort: assert property (p_abort) else $error("deselect did not abort");

	property p_reserved;
		wr_go && cmd.kind == cca_pkg::K_GLOBAL && (cur_reg == 5'h1a || cur_reg == 5'h1b)
			|-> !g_ok;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved global taken");

	property p_id_first;
		clk_en && !gci && state == cca_pkg::S_CMD && in_v && !in_cmd.wr
			&& in_cmd.kind != cca_pkg::K_ILLEGAL && in_cmd.kind != cca_pkg::K_MEM
			|=> mon_tx.data == ID_CODE ##0 state == cca_pkg::S_RD;
	endproperty
	a_id_first: assert property (p_id_first) else $error("id byte missing");

	property p_ps_reply;
		clk_en && gci && state == cca_pkg::S_CMD && in_v && !in_cmd.wr
			&& in_cmd.kind == cca_pkg::K_GLOBAL
			|=> mon_tx.valid && mon_tx.data[7:5] == 3'h4 && mon_tx.data[3:0] == 4'h1;
	endproperty
	a_ps_reply: assert property (p_ps_reply) else $error("reply lacks start byte");

	property p_count;
		clk_en && wr_go && cmd.kind != cca_pkg::K_MEM && cnt == {3'h0, cmd.addr[1:0]}
			|=> state != cca_pkg::S_WR;
	endproperty
	a_count: assert property (p_count) else $error("byte count wrong");

	property p_top_word;
		state == cca_pkg::S_WR && cmd.kind == cca_pkg::K_MEM && cnt == 5'h00 |-> cur_word == 3'h7;
	endproperty
	a_top_word: assert property (p_top_word) else $error("block not top first");

	property p_repeat;
		gci && state == cca_pkg::S_RD && !(mon_frame && fcnt) |=> $stable(mon_tx.data);
	endproperty
	a_repeat: assert property (p_repeat) else $error("upstream byte not held two frames");

	property p_gci_noabort;
		gci && state == cca_pkg::S_WR |=> state == cca_pkg::S_WR || state == cca_pkg::S_IDLE;
	endproperty
	a_gci_noabort: assert property (p_gci_noabort) else $error("monitor write broken");

	c_serial_write: cover property (!gci && wr_go && cmd.kind == cca_pkg::K_MEM && cnt == 5'h0f);
	c_gci_read: cover property (gci && state == cca_pkg::S_RD ##1 state == cca_pkg::S_IDLE);
	c_abort: cover property (!gci && cs_end && state == cca_pkg::S_WR);
endmodule

// file: tb/cca_host.sv
`timescale 1ns/100ps
// host controller on the serial port: sclk stands still between bytes
module cca_host (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	// idle host: deselected, clock parked high
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		sdi  = 1'b0;
	end

	// chip select low marks the command byte as the next byte
	task automatic open_cmd();
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// released data line shows the inverse of its last bit, never a held value
	task automatic close_cmd();
		cs_n <= 1'b1;
		sdi  <= ~sdi;
		repeat (8) @(posedge clk);
	endtask

	// msb first; reply bit taken at the end of the high phase, before the fall moves it
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int gap);
		for (int i = 7; i >= 0; i--) begin
			sclk <= 1'b0;
			sdi  <= tx[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			rx[i] = sdo;
		end
		repeat (gap) @(posedge clk); // a slow host stretches the gap
	endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [7:0] ID = 8'h5a; // arbitrary identification value
	logic               clk = 1'b0;
	logic               rst_n;
	logic               clk_en;
	logic               gci_mode;
	logic               mon_frame;
	logic [1:0]         slot_select_pin;
	cca_pkg::cca_byte_t mon_rx;
	cca_pkg::cca_byte_t mon_tx;
	logic               cs_n;
	logic               sclk;
	logic               serial_cmd_in;
	logic               serial_reply_out;
	logic               cmd_busy;
	logic [7:0]         q[$];
	logic [7:0]         e[$];
	cca_pkg::cca_byte_t s[$];
	int                 num_errors = 0;
	int                 comparisons = 0;

	// 40 MHz system clock
	always #12.5 clk = ~clk;

	cca_core #(.ID_CODE(ID)) i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n),
		.sclk(sclk), .serial_cmd_in(serial_cmd_in), .gci_mode(gci_mode),
		.slot_select_pin(slot_select_pin), .mon_frame(mon_frame), .mon_rx(mon_rx),
		.serial_reply_out(serial_reply_out), .mon_tx(mon_tx), .cmd_busy(cmd_busy));

	cca_host i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(serial_cmd_in),
		.sdo(serial_reply_out));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d, num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// end a command and wait, bounded, for the block to go idle
	task automatic finish_cmd();
		int n;
		n = 0;
		i_host.close_cmd();
		while (cmd_busy !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (cmd_busy !== 1'b0) begin
			num_errors++;
			tally_and_finish();
		end
	endtask

	// command and data bytes from q in one chip-select period
	task automatic ser_wr();
		logic [7:0] r;
		i_host.open_cmd();
		foreach (q[i]) i_host.xfer(q[i], r, 4);
		finish_cmd();
	endtask

	// read: busy after the command, then id byte, then the bytes in e
	task automatic ser_rd(input logic [7:0] cmd);
		logic [7:0] r;
		i_host.open_cmd();
		i_host.xfer(cmd, r, 4);
		check("busy", {7'h00, cmd_busy}, 8'h01);
		i_host.xfer(8'hff, r, 12);
		check("id byte", r, ID);
		foreach (e[i]) begin
			i_host.xfer(8'hff, r, 4);
			check("reply byte", r, e[i]);
		end
		finish_cmd();
	endtask

	// one monitor frame; upstream byte taken late in the frame when settled
	task automatic frame(input cca_pkg::cca_byte_t v);
		mon_rx    <= v;
		mon_frame <= 1'b1;
		@(posedge clk);
		mon_frame <= 1'b0;
		repeat (7) @(posedge clk);
		s.push_back(mon_tx);
	endtask

	// bytes of q each sent twice then a blank frame; reply checked every second frame
	task automatic mon_run(input int extra);
		int k;
		logic [7:0] d;
		logic v;
		s.delete();
		foreach (q[i]) begin
			frame({1'b1, q[i]});
			frame({1'b1, q[i]});
			frame(9'h000);
		end
		repeat (extra) frame(9'h000);
		k = 0;
		while (k < s.size() && s[k].valid !== 1'b1) k++;
		foreach (e[i]) begin
			d = (k + 2 * i < s.size()) ? s[k + 2 * i].data : 8'hxx;
			check("monitor byte", d, e[i]);
		end
		// after the last reply byte the upstream valid must drop
		k = k + 2 * e.size();
		v = (k < s.size()) ? s[k].valid : 1'b1;
		if (e.size() > 0) check("reply end", {7'h00, v}, 8'h00);
	endtask

	// full block write, then a second write cut off inside word six
	task automatic mem_test(input logic [7:0] wcmd, input logic [7:0] rcmd, input logic [7:0] m);
		q = '{wcmd};
		for (int i = 0; i < 16; i++) q.push_back(8'h30 + 8'(i));
		ser_wr();
		q = '{wcmd, 8'hc7, 8'hcb, 8'he1};
		ser_wr();
		e = '{8'hc7, 8'hcb & m};
		for (int i = 2; i < 16; i++) e.push_back((8'h30 + 8'(i)) & (i[0] ? m : 8'hff));
		ser_rd(rcmd);
	endtask

	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rst_n           = 1'b0;
		clk_en          = 1'b1;
		gci_mode        = 1'b0;
		slot_select_pin = 2'h0;
		mon_frame       = 1'b0;
		mon_rx          = 9'h000;
		repeat (4) @(posedge clk);
		check("reset monitor", mon_tx.data, 8'h00);
		check("reset busy", {7'h00, cmd_busy}, 8'h00);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		q = '{8'ha5, 8'h01};
		ser_wr();
		e = '{8'h01};
		ser_rd(8'h25);
		q = '{8'h83, 8'h11, 8'h22, 8'h33, 8'h44};
		ser_wr();
		e = '{8'h11, 8'h22, 8'h33, 8'h44};
		ser_rd(8'h03);
		q = '{8'hc1, 8'h99};
		ser_wr();
		e = '{8'h33, 8'h44};
		ser_rd(8'h01);
		q = '{8'h83, 8'h55, 8'h66};
		ser_wr();
		e = '{8'h55, 8'h66, 8'h33, 8'h44};
		ser_rd(8'h03);
		q = '{8'hba, 8'h99};
		ser_wr();
		e = '{8'h00, 8'h00, 8'h00};
		ser_rd(8'h3a);
		q = '{8'hbc, 8'h77};
		ser_wr();
		e = '{8'h77};
		ser_rd(8'h3c);
		q = '{8'hb9, 8'hc3, 8'h01};
		ser_wr();
		e = '{8'hc3, 8'h01};
		ser_rd(8'h39);
		mem_test(8'he4, 8'h64, 8'hfc);
		mem_test(8'hf2, 8'h72, 8'hff);
		q = '{8'ha5, 8'h03};
		ser_wr();
		q = '{8'h80, 8'h24};
		ser_wr();
		gci_mode <= 1'b1;
		repeat (4) @(posedge clk);
		q = '{8'h91, 8'h00};
		e = '{8'h91, 8'h24};
		mon_run(4);
		q = '{8'h81, 8'h80, 8'h42};
		e = {};
		mon_run(0);
		q = '{8'h81, 8'h01};
		e = '{8'h81, 8'h33, 8'h42};
		mon_run(6);
		slot_select_pin <= 2'h1;
		q = '{8'h91, 8'h3c};
		e = '{8'h91, 8'h77};
		mon_run(4);
		tally_and_finish();
	end
endmodule
